/* src/shifter_pkg.sv */
// Package holding constants and types of the barrel shifter datapath.
package shifter_pkg;

    localparam int DATA_W = 16;
    localparam int CODE_W = 8;
    localparam int BEXP_W = 5;
    localparam int BANK_BIT = 0;
    localparam logic [CODE_W-1:0] LO_OFFSET = 8'h10;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_EXP = 8'h00;
    localparam logic [4:0] RESET_BEXP = 5'h00;

    typedef enum logic [1:0] {
        CODE_EXP = 2'h0,
        CODE_NEG = 2'h1,
        CODE_IMM = 2'h2
    } code_src_t;

    typedef enum logic [1:0] {
        EXT_SIGN = 2'h0,
        EXT_CARRY = 2'h1,
        EXT_ZERO = 2'h2
    } ext_src_t;

    typedef enum logic [2:0] {
        REG_INPUT = 3'h0,
        REG_RES_LOW = 3'h1,
        REG_RES_HIGH = 3'h2,
        REG_EXP = 3'h3,
        REG_BEXP = 3'h4
    } reg_sel_t;

    typedef struct packed {
        logic        shift_en;
        logic        use_result_bus;
        code_src_t   code_src;
        logic [7:0]  imm_code;
        logic        half_reference_select;
        ext_src_t    ext_src;
        logic        or_mode;
    } shift_op_t;

    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        reg_sel_t    wr_sel;
        reg_sel_t    rd_sel;
        logic [15:0] wr_data;
    } bus_req_t;

endpackage : shifter_pkg

/* src/barrel_shifter_datapath.sv */
// Barrel shifter datapath with banked input, result and exponent registers.
`timescale 1ns/100ps
`default_nettype none
module barrel_shifter_datapath #(
    parameter int DATA_W = shifter_pkg::DATA_W,
    parameter int CODE_W = shifter_pkg::CODE_W,
    parameter int BEXP_W = shifter_pkg::BEXP_W
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire shifter_pkg::shift_op_t  op,
    input  wire logic [15:0]             result_bus_in,
    input  wire logic                    alu_carry_flag,
    input  wire logic [15:0]             mode_status_reg,
    input  wire shifter_pkg::bus_req_t   dm_req,
    input  wire logic                    block_exp_load,
    input  wire logic [4:0]              block_exp_value,
    input  wire logic                    shift_exp_load,
    input  wire logic [7:0]              shift_exp_value,
    output logic [15:0]                  data_memory_bus_out,
    output logic [15:0]                  result_low_out,
    output logic [15:0]                  result_high_out,
    output logic [15:0]                  detector_operand
);

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] input_reg    [2];
    logic [15:0] res_low_reg  [2];
    logic [15:0] res_high_reg [2];
    logic [7:0]  exp_reg      [2];
    logic [4:0]  bexp_reg     [2];
    logic [15:0] input_next   [2];
    logic [15:0] res_low_next [2];
    logic [15:0] res_high_next[2];
    logic [7:0]  exp_next     [2];
    logic [4:0]  bexp_next    [2];
    logic [15:0] bus_out_next;
    logic [15:0] bus_out_reg;

    logic        bank;
    logic [15:0] operand;
    logic [7:0]  code;
    logic        ext_bit;
    logic [31:0] array_out;
    logic [31:0] merged;

    ////////////////////////////////////////////////////////////////////////////
    // The array, the merge and the register map are built for the documented widths only.
    if (DATA_W != shifter_pkg::DATA_W || CODE_W != shifter_pkg::CODE_W || BEXP_W != shifter_pkg::BEXP_W) begin : g_width_check
        $error("Unsupported shifter datapath widths.");
    end

    assign bank = mode_status_reg[shifter_pkg::BANK_BIT];
    assign operand = op.use_result_bus ? result_bus_in : input_reg[bank];
    assign detector_operand = operand;

    ////////////////////////////////////////////////////////////////////////////
    // Shifter array: the operand sits in a 64-bit frame, then the 32-bit window is picked.
    always_comb begin
        logic [63:0] frame;
        logic signed [8:0] amt;
        frame = 64'h0;
        amt = 9'sh000;
        unique case (op.code_src)
            shifter_pkg::CODE_EXP: code = exp_reg[bank];
            shifter_pkg::CODE_NEG: code = 8'(-exp_reg[bank]);
            default:               code = op.imm_code;
        endcase
        unique case (op.ext_src)
            shifter_pkg::EXT_SIGN:  ext_bit = operand[15];
            shifter_pkg::EXT_CARRY: ext_bit = alu_carry_flag;
            default:                ext_bit = 1'b0;
        endcase
        // A low-referenced code places the operand like a high-referenced code smaller by 16.
        amt = $signed({code[7], code});
        if (!op.half_reference_select) begin
            amt = amt - $signed({1'b0, shifter_pkg::LO_OFFSET});
        end
        // Operand initially at bits 31..16 of the output (high reference, code 0).
        if (amt >= 9'sh010) begin
            array_out = 32'h0;
        end else if (amt <= -9'sh020) begin
            array_out = {32{ext_bit}};
        end else begin
            frame = {{16{ext_bit}}, operand, 32'h0};
            frame = frame << 16;
            if (amt >= 0) begin
                frame = frame << amt[4:0];
            end else begin
                frame = (frame >> 6'(-amt)) | ~({64{1'b1}} >> 6'(-amt)) & {64{ext_bit}};
            end
            array_out = frame[63:32];
        end
        merged = op.or_mode ? (array_out | {res_high_reg[bank], res_low_reg[bank]}) : array_out;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register next values; only the visible bank changes.
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            input_next[b]    = input_reg[b];
            res_low_next[b]  = res_low_reg[b];
            res_high_next[b] = res_high_reg[b];
            exp_next[b]      = exp_reg[b];
            bexp_next[b]     = bexp_reg[b];
        end
        if (op.shift_en) begin
            res_high_next[bank] = merged[31:16];
            res_low_next[bank]  = merged[15:0];
        end
        if (shift_exp_load) begin
            exp_next[bank] = shift_exp_value;
        end
        if (block_exp_load) begin
            bexp_next[bank] = block_exp_value;
        end
        if (dm_req.wr_en) begin
            unique case (dm_req.wr_sel)
                shifter_pkg::REG_INPUT:    input_next[bank]    = dm_req.wr_data;
                shifter_pkg::REG_RES_LOW:  res_low_next[bank]  = dm_req.wr_data;
                shifter_pkg::REG_RES_HIGH: res_high_next[bank] = dm_req.wr_data;
                shifter_pkg::REG_EXP:      exp_next[bank]      = dm_req.wr_data[7:0];
                shifter_pkg::REG_BEXP:     bexp_next[bank]     = dm_req.wr_data[4:0];
                default: ;
            endcase
        end
        bus_out_next = 16'h0000;
        if (dm_req.rd_en) begin
            unique case (dm_req.rd_sel)
                shifter_pkg::REG_INPUT:    bus_out_next = input_reg[bank];
                shifter_pkg::REG_RES_LOW:  bus_out_next = res_low_reg[bank];
                shifter_pkg::REG_RES_HIGH: bus_out_next = res_high_reg[bank];
                shifter_pkg::REG_EXP:      bus_out_next = {{8{exp_reg[bank][7]}}, exp_reg[bank]};
                shifter_pkg::REG_BEXP:     bus_out_next = {{11{bexp_reg[bank][4]}}, bexp_reg[bank]};
                default:                   bus_out_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int b = 0; b < 2; b++) begin
                input_reg[b]    <= shifter_pkg::RESET_WORD;
                res_low_reg[b]  <= shifter_pkg::RESET_WORD;
                res_high_reg[b] <= shifter_pkg::RESET_WORD;
                exp_reg[b]      <= shifter_pkg::RESET_EXP;
                bexp_reg[b]     <= shifter_pkg::RESET_BEXP;
            end
            bus_out_reg <= shifter_pkg::RESET_WORD;
        end else begin
            for (int b = 0; b < 2; b++) begin
                input_reg[b]    <= input_next[b];
                res_low_reg[b]  <= res_low_next[b];
                res_high_reg[b] <= res_high_next[b];
                exp_reg[b]      <= exp_next[b];
                bexp_reg[b]     <= bexp_next[b];
            end
            bus_out_reg <= bus_out_next;
        end
    end

    assign data_memory_bus_out = bus_out_reg;
    assign result_low_out  = res_low_reg[bank];
    assign result_high_out = res_high_reg[bank];

    ////////////////////////////////////////////////////////////////////////////
    sequence s_shift_pass;
        op.shift_en && !op.or_mode && !(dm_req.wr_en &&
            (dm_req.wr_sel == shifter_pkg::REG_RES_LOW || dm_req.wr_sel == shifter_pkg::REG_RES_HIGH));
    endsequence

    chk_pass_result_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_shift_pass |=> {res_high_reg[$past(bank)], res_low_reg[$past(bank)]} == $past(array_out))
        else $error("Pass shift did not load array output.");

    chk_zero_high_code: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.half_reference_select && op.code_src == shifter_pkg::CODE_IMM && op.imm_code == 8'h00
        |-> array_out == {operand, 16'h0000})
        else $error("Code zero high reference misplaced operand.");

    chk_low_ref_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        !op.half_reference_select && op.code_src == shifter_pkg::CODE_IMM && op.imm_code == 8'h00
        |-> array_out[15:0] == operand)
        else $error("Low reference code zero misplaced operand.");

    chk_off_left: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.half_reference_select && op.code_src == shifter_pkg::CODE_IMM && op.imm_code == 8'h10
        |-> array_out == 32'h0)
        else $error("Off-scale left not zero.");

    chk_off_right: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.half_reference_select && op.code_src == shifter_pkg::CODE_IMM && op.imm_code == 8'hE0
        |-> array_out == {32{ext_bit}})
        else $error("Off-scale right not extension.");

    chk_zero_ext: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.ext_src == shifter_pkg::EXT_ZERO |-> ext_bit == 1'b0)
        else $error("Zero extension not zero.");

    chk_exp_sign_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.rd_en && dm_req.rd_sel == shifter_pkg::REG_EXP
        |=> data_memory_bus_out == {{8{$past(exp_reg[bank][7])}}, $past(exp_reg[bank])})
        else $error("Exponent read not sign-extended.");

    chk_read_old: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.rd_en && dm_req.wr_en && dm_req.rd_sel == shifter_pkg::REG_INPUT
        && dm_req.wr_sel == shifter_pkg::REG_INPUT
        |=> data_memory_bus_out == $past(input_reg[bank]) && input_reg[$past(bank)] == $past(dm_req.wr_data))
        else $error("Same-cycle read and write conflict.");

    chk_bank_hidden: assert property (@(posedge ref_clk) disable iff (!rstn)
        bank == 1'b0 |=> $stable(input_reg[1]) && $stable(exp_reg[1]))
        else $error("Hidden bank changed.");

    chk_bank_one_hidden: assert property (@(posedge ref_clk) disable iff (!rstn)
        mode_status_reg[shifter_pkg::BANK_BIT] |=> $stable(input_reg[0]) && $stable(exp_reg[0])
            && $stable(res_low_reg[0]) && $stable(res_high_reg[0]) && $stable(bexp_reg[0]))
        else $error("Primary bank changed while hidden.");

    ////////////////////////////////////////////////////////////////////////////
    // Sources of the control code, the extension bit and the operand.
    chk_exp_code_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.code_src == shifter_pkg::CODE_EXP |-> code == exp_reg[bank])
        else $error("Exponent code source wrong.");

    chk_neg_code_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.code_src == shifter_pkg::CODE_NEG |-> 8'(code + exp_reg[bank]) == 8'h00)
        else $error("Negated exponent code source wrong.");

    chk_imm_code_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.code_src == shifter_pkg::CODE_IMM |-> code == op.imm_code)
        else $error("Immediate code source wrong.");

    chk_sign_ext_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.ext_src == shifter_pkg::EXT_SIGN |-> ext_bit == operand[15])
        else $error("Sign extension source wrong.");

    chk_carry_ext_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.ext_src == shifter_pkg::EXT_CARRY |-> ext_bit == alu_carry_flag)
        else $error("Carry extension source wrong.");

    chk_result_bus_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.use_result_bus |-> detector_operand == result_bus_in)
        else $error("Result bus operand not used.");

    chk_input_reg_src: assert property (@(posedge ref_clk) disable iff (!rstn)
        !op.use_result_bus |-> detector_operand == input_reg[bank])
        else $error("Input register operand not used.");

    ////////////////////////////////////////////////////////////////////////////
    // Fill on both sides of the placed operand.
    chk_right_zero_fill: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.half_reference_select && !code[7] |-> array_out[15:0] == 16'h0000)
        else $error("Right fill not zero.");

    chk_left_ext_fill: assert property (@(posedge ref_clk) disable iff (!rstn)
        op.half_reference_select && code[7] |-> array_out[31] == ext_bit)
        else $error("Left fill not extension bit.");

    ////////////////////////////////////////////////////////////////////////////
    // Merge and register loads; a bus write to a register wins over a load from the datapath.
    sequence s_shift_or;
        op.shift_en && op.or_mode && !(dm_req.wr_en &&
            (dm_req.wr_sel == shifter_pkg::REG_RES_LOW || dm_req.wr_sel == shifter_pkg::REG_RES_HIGH));
    endsequence

    chk_or_merge_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_shift_or |=> {res_high_reg[$past(bank)], res_low_reg[$past(bank)]}
            == ($past(array_out) | {$past(res_high_reg[bank]), $past(res_low_reg[bank])}))
        else $error("OR merge did not combine result.");

    chk_input_bus_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_INPUT
        |=> input_reg[$past(bank)] == $past(dm_req.wr_data))
        else $error("Input register write lost.");

    chk_bus_write_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_RES_LOW
        |=> res_low_reg[$past(bank)] == $past(dm_req.wr_data))
        else $error("Result low write lost.");

    chk_bus_write_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_RES_HIGH
        |=> res_high_reg[$past(bank)] == $past(dm_req.wr_data))
        else $error("Result high write lost.");

    chk_exp_bus_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_EXP
        |=> exp_reg[$past(bank)] == $past(dm_req.wr_data[7:0]))
        else $error("Exponent write lost.");

    chk_bexp_bus_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_BEXP
        |=> bexp_reg[$past(bank)] == $past(dm_req.wr_data[4:0]))
        else $error("Block exponent write lost.");

    chk_bexp_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        block_exp_load && !(dm_req.wr_en && dm_req.wr_sel == shifter_pkg::REG_BEXP)
        |=> bexp_reg[$past(bank)] == $past(block_exp_value))
        else $error("Block exponent load lost.");

    chk_bexp_sign_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        dm_req.rd_en && dm_req.rd_sel == shifter_pkg::REG_BEXP
        |=> data_memory_bus_out == {{11{$past(bexp_reg[bank][4])}}, $past(bexp_reg[bank])})
        else $error("Block exponent read not sign-extended.");

    chk_idle_read_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        !dm_req.rd_en |=> data_memory_bus_out == 16'h0000)
        else $error("Bus output not zero without read.");

endmodule : barrel_shifter_datapath
`default_nettype wire

/* sim/result_bus_model.sv */
// Model of the processor result bus that offers a second operand source.
`timescale 1ns/100ps
`default_nettype none
module result_bus_model (
    input  wire logic [1:0]  src_sel,
    input  wire logic [15:0] alu_result_reg,
    input  wire logic [15:0] multiplier_accum_reg,
    input  wire logic [15:0] shift_feedback,
    output logic [15:0]      result_bus
);
    // Only one result register drives the bus at a time.
    assign result_bus = (src_sel == 2'h0) ? alu_result_reg :
                        (src_sel == 2'h1) ? multiplier_accum_reg : shift_feedback;
endmodule : result_bus_model
`default_nettype wire

/* sim/barrel_shifter_datapath_tb_top.sv */
// Self-checking bench for the barrel shifter datapath.
`timescale 1ns/100ps
`default_nettype none
module barrel_shifter_datapath_tb_top;
    logic                   ref_clk = 1'b0;
    logic                   rstn = 1'b0;
    shifter_pkg::shift_op_t op = '0;
    shifter_pkg::bus_req_t  dm_req = '0;
    logic [15:0]            msr = 16'h0000;
    logic                   carry = 1'b1;
    logic                   se_ld = 1'b0;
    logic [7:0]             se_val = 8'h00;
    logic [1:0]             rb_sel = 2'h0;
    logic [15:0]            rb, dout, rlo, rhi, det;
    logic [31:0]            acc;
    int                     error_cnt = 0;
    int                     check_count = 0;
    logic [7:0]             codes [9] = '{8'h00, 8'hFC, 8'h08, 8'h10, 8'h0F, 8'hF0, 8'hE0, 8'h14, 8'hF8};
    logic [8:0]             hiv = 9'b001011111;

    initial forever #4 ref_clk = ~ref_clk;

    result_bus_model partner (.src_sel(rb_sel), .alu_result_reg(16'h8001), .multiplier_accum_reg(16'h7F00),
        .shift_feedback(rhi), .result_bus(rb));

    barrel_shifter_datapath dut (.ref_clk(ref_clk), .rstn(rstn), .op(op), .result_bus_in(rb),
        .alu_carry_flag(carry), .mode_status_reg(msr), .dm_req(dm_req), .block_exp_load(se_ld),
        .block_exp_value(se_val[4:0]), .shift_exp_load(se_ld), .shift_exp_value(se_val),
        .data_memory_bus_out(dout), .result_low_out(rlo), .result_high_out(rhi), .detector_operand(det));

    ////////////////////////////////////////////////////////////////////////////////
    // Expected placement: operand with extension bits above and zeros below.
    function automatic logic [31:0] place(input logic [15:0] d, input logic [7:0] c, input logic hi,
                                          input logic [1:0] xs);
        int           pos;
        logic         x;
        logic [127:0] t;
        x = (xs == 2'h0) ? d[15] : (xs == 2'h1) ? carry : 1'b0;
        pos = $signed(c) + (hi ? 16 : 0);
        if (pos > 40) pos = 40;
        if (pos < -20) pos = -20;
        t = {{48{x}}, d, 64'h0};
        t = t >> (64 - pos);
        return t[31:0];
    endfunction : place

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic r, input logic [2:0] s, input logic [15:0] d,
                       input logic [15:0] exp);
        @(posedge ref_clk);
        dm_req <= '{w, r, shifter_pkg::reg_sel_t'(s), shifter_pkg::reg_sel_t'(s), d};
        @(posedge ref_clk);
        dm_req <= '0;
        #1;
        if (r) chk({16'h0000, dout}, {16'h0000, exp});
    endtask : bus

    task automatic sh(input shifter_pkg::code_src_t cs, input logic [7:0] c, input logic hi,
                      input logic [1:0] x, input logic orm, input logic rbus, input logic [31:0] exp);
        @(posedge ref_clk);
        op <= '{1'b1, rbus, cs, c, hi, shifter_pkg::ext_src_t'(x), orm};
        @(posedge ref_clk);
        op <= '0;
        #1;
        chk({rhi, rlo}, exp);
    endtask : sh

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        wrap_up;
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int s = 0; s < 5; s++) bus(1'b0, 1'b1, 3'(s), 16'h0000, 16'h0000);
        bus(1'b0, 1'b1, 3'h7, 16'h0000, 16'h0000);
        bus(1'b1, 1'b0, 3'h0, 16'hA5C3, 16'h0000);
        chk({16'h0000, det}, 32'h0000A5C3);
        bus(1'b1, 1'b1, 3'h3, 16'h12F0, 16'h0000);
        bus(1'b0, 1'b1, 3'h3, 16'h0000, 16'hFFF0);
        bus(1'b1, 1'b0, 3'h4, 16'h0013, 16'h0000);
        bus(1'b0, 1'b1, 3'h4, 16'h0000, 16'hFFF3);
        bus(1'b1, 1'b0, 3'h1, 16'h1111, 16'h0000);
        bus(1'b1, 1'b1, 3'h1, 16'h2222, 16'h1111);
        bus(1'b1, 1'b1, 3'h2, 16'h3333, 16'h0000);
        bus(1'b0, 1'b1, 3'h2, 16'h0000, 16'h3333);
        for (int i = 0; i < 9; i++)
            sh(shifter_pkg::CODE_IMM, codes[i], hiv[i], 2'(i % 3), 1'b0, 1'b0,
               place(16'hA5C3, codes[i], hiv[i], 2'(i % 3)));
        sh(shifter_pkg::CODE_IMM, 8'h00, 1'b0, 2'h0, 1'b0, 1'b0, 32'hFFFFA5C3);
        @(posedge ref_clk);
        se_ld <= 1'b1;
        se_val <= 8'hFD;
        @(posedge ref_clk);
        se_ld <= 1'b0;
        bus(1'b0, 1'b1, 3'h3, 16'h0000, 16'hFFFD);
        bus(1'b0, 1'b1, 3'h4, 16'h0000, 16'hFFFD);
        sh(shifter_pkg::CODE_EXP, 8'h00, 1'b1, 2'h0, 1'b0, 1'b0, place(16'hA5C3, 8'hFD, 1'b1, 2'h0));
        sh(shifter_pkg::CODE_NEG, 8'h00, 1'b1, 2'h0, 1'b0, 1'b0, place(16'hA5C3, 8'h03, 1'b1, 2'h0));
        sh(shifter_pkg::CODE_IMM, 8'h04, 1'b0, 2'h1, 1'b0, 1'b1, place(16'h8001, 8'h04, 1'b0, 2'h1));
        @(posedge ref_clk);
        rb_sel <= 2'h1;
        sh(shifter_pkg::CODE_IMM, 8'hFF, 1'b1, 2'h0, 1'b0, 1'b1, place(16'h7F00, 8'hFF, 1'b1, 2'h0));
        @(posedge ref_clk);
        rb_sel <= 2'h2;
        sh(shifter_pkg::CODE_IMM, 8'h00, 1'b1, 2'h0, 1'b0, 1'b1, 32'h3F800000);
        acc = place(16'hA5C3, 8'hFC, 1'b1, 2'h0);
        sh(shifter_pkg::CODE_IMM, 8'hFC, 1'b1, 2'h0, 1'b0, 1'b0, acc);
        bus(1'b1, 1'b1, 3'h0, 16'h0F0F, 16'hA5C3);
        acc = acc | place(16'h0F0F, 8'hFC, 1'b0, 2'h2);
        sh(shifter_pkg::CODE_IMM, 8'hFC, 1'b0, 2'h2, 1'b1, 1'b0, acc);
        @(posedge ref_clk);
        msr <= 16'h0001;
        bus(1'b0, 1'b1, 3'h0, 16'h0000, 16'h0000);
        bus(1'b1, 1'b0, 3'h0, 16'h1234, 16'h0000);
        sh(shifter_pkg::CODE_IMM, 8'h00, 1'b1, 2'h0, 1'b0, 1'b0, 32'h12340000);
        @(posedge ref_clk);
        msr <= 16'h0000;
        bus(1'b0, 1'b1, 3'h0, 16'h0000, 16'h0F0F);
        chk({rhi, rlo}, acc);
        wrap_up;
    end
endmodule : barrel_shifter_datapath_tb_top
`default_nettype wire
